// [infrared_pulse_endec.sv]
// infrared pulse encoder/decoder between uart and ir transceiver
`timescale 1ns/100ps
module infrared_pulse_endec
#(
   parameter int unsigned BIT_TICKS = ir_endec_pkg::TICKS_PER_BIT, // baud ticks per bit
   parameter int unsigned DIVISOR_W = 16                           // divisor bits, two bytes
)
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_infrared_codec_enable,
   input  wire logic [7:0] i_divisor_high,
   input  wire logic [7:0] i_divisor_low,
   input  wire logic       i_uart_txd,
   input  wire logic       i_rxd_pin,
   output logic            o_txd_pin,
   output logic            o_uart_rxd,
   output logic            o_baud_tick,
   output logic            o_rx_busy
);
   import ir_endec_pkg::*;

   logic [15:0] baud_divisor_value;
   logic [15:0] div_cnt_q;
   logic [15:0] div_cnt_d;
   logic        tick_q;
   logic        tick;
   logic [3:0]  tx_cnt_q;
   logic        tx_bit_q;
   logic        tx_bit_d;
   logic        tx_pulse;
   logic        ir_modulated_out;
   logic        txd_pin_d;
   logic        rx_meta_q;
   logic        rx_sync_q;
   logic        rx_prev_q;
   logic        rx_fall;
   logic        ir_pulse_in;
   logic [3:0]  rx_cnt_q;
   logic [3:0]  rx_cnt_d;
   rx_state_e   rx_state_q;
   rx_state_e   rx_state_d;
   logic        rx_level_q;
   logic        rx_level_d;
   logic        bit_zero_q;
   logic        bit_zero_d;
   logic        uart_rxd_d;
   logic        tx_frame_end;
   logic [3:0]  rx_cnt_inc;
   logic        rx_at_update;
   logic        rx_at_window;
   logic        rx_busy_d;

   // counters are four bits and the divisor two bytes wide; other
   // values would need a wider datapath than this block has
   if (BIT_TICKS != 2 ** $bits(tx_cnt_q) || DIVISOR_W != $bits(baud_divisor_value))
   begin : g_param_check
      $error("infrared_pulse_endec: unsupported width parameters");
   end

   // window must open after the level update or a bit is never decoded
   if (RX_WIN_OPEN <= RX_UPDATE_CNT || TX_PULSE_END <= TX_PULSE_START)
   begin : g_count_check
      $error("infrared_pulse_endec: inconsistent count constants");
   end

   // next value of a four-bit tick counter; wraps from fifteen to zero
   function automatic logic [3:0] next_count(input logic [3:0] cnt);
      next_count = cnt + 4'h1;
   endfunction : next_count

   // divisor zero is treated as one so the tick never stops
   assign baud_divisor_value = {i_divisor_high, i_divisor_low};
   assign tick      = tick_q;
   assign div_cnt_d = (div_cnt_q >= baud_divisor_value || div_cnt_q == DIVISOR_RESET) ?
                      DIVISOR_ONE : div_cnt_q + DIVISOR_ONE;

   // divisor count: one tick per divisor clocks, 16 per bit gives
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         div_cnt_q <= DIVISOR_ONE;
      else
         div_cnt_q <= div_cnt_d;
   end

   // baud tick, registered; a one-clock pulse for divisors above one, held high for divisors zero and one
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         tick_q <= 1'b0;
      else
         tick_q <= (div_cnt_q >= baud_divisor_value);
   end

   // transmit: bit sampled at tick fifteen, the last of each 16-tick frame
   assign tx_frame_end = tick && (tx_cnt_q == CNT_LAST);
   assign tx_bit_d = tx_frame_end ? i_uart_txd : tx_bit_q;
   assign tx_pulse = (tx_cnt_q >= TX_PULSE_START) && (tx_cnt_q < TX_PULSE_END);
   assign ir_modulated_out = ~tx_bit_q & tx_pulse & ~o_rx_busy;

   // free-running frame count; not aligned to txd edges
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         tx_cnt_q <= CNT_LAST;
      else if (tick)
         tx_cnt_q <= next_count(tx_cnt_q);
   end

   // bit held for a whole frame so a mid-frame txd change cannot chop a pulse
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         tx_bit_q <= 1'b1;
      else
         tx_bit_q <= tx_bit_d;
   end

   // pin selection; the uart stays untouched so holds by design
   assign txd_pin_d = i_infrared_codec_enable ? ir_modulated_out : i_uart_txd;
   assign uart_rxd_d = i_infrared_codec_enable ? rx_level_q : rx_sync_q;

   // receive pin synchroniser, first stage; read only by the second
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         rx_meta_q <= 1'b0;
      else
         rx_meta_q <= i_rxd_pin;
   end

   // second stage resets to the dark level so reset makes no false edge
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         rx_sync_q <= 1'b0;
      else
         rx_sync_q <= rx_meta_q;
   end

   // previous level for the falling edge detector
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         rx_prev_q <= 1'b0;
      else
         rx_prev_q <= rx_sync_q;
   end

   // pulses are active high; falling edge ends a pulse
   assign ir_pulse_in = rx_sync_q;
   assign rx_fall = rx_prev_q & ~ir_pulse_in & i_infrared_codec_enable;

   // counter decode shared by the RX_FIRST and RX_WINDOW decoder states
   assign rx_cnt_inc   = next_count(rx_cnt_q);
   assign rx_at_update = tick && (rx_cnt_inc == RX_UPDATE_CNT);
   assign rx_at_window = tick && (rx_cnt_inc == RX_WIN_OPEN);
   assign rx_busy_d    = (rx_state_d != RX_IDLE);

   // decoder: counter restarts on a falling edge in idle or window, window 12..8
   always_comb
   begin
      rx_state_d = rx_state_q;
      rx_cnt_d   = rx_cnt_q;
      rx_level_d = rx_level_q;
      bit_zero_d = bit_zero_q;
      case (rx_state_q)
         RX_IDLE:
         begin
            if (rx_fall)
            begin
               rx_state_d = RX_FIRST;
               rx_cnt_d   = 4'h0;
               bit_zero_d = 1'b1;
            end
         end
         RX_FIRST:
         begin
            if (tick)
               rx_cnt_d = rx_cnt_inc;
            if (rx_at_update)
            begin
               rx_level_d = ~bit_zero_q;
               bit_zero_d = 1'b0;
            end
            if (rx_at_window)
               rx_state_d = RX_WINDOW;
         end
         RX_WINDOW:
         begin
            if (tick)
               rx_cnt_d = rx_cnt_inc;
            if (rx_fall)
            begin
               rx_state_d = RX_FIRST;
               rx_cnt_d   = 4'h0;
               bit_zero_d = 1'b1;
            end
            else if (rx_at_update)
            begin
               rx_level_d = 1'b1;
               rx_state_d = RX_IDLE;
            end
         end
         default:
            rx_state_d = RX_IDLE;
      endcase
      if (!i_infrared_codec_enable)
      begin
         rx_state_d = RX_IDLE;
         rx_level_d = 1'b1;
      end
   end

   // decoder state; leaves idle only on a detected falling edge
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         rx_state_q <= RX_IDLE;
      else
         rx_state_q <= rx_state_d;
   end

   // ticks since the last falling edge
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         rx_cnt_q <= 4'h0;
      else
         rx_cnt_q <= rx_cnt_d;
   end

   // regenerated uart level; idles high like a uart line
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         rx_level_q <= 1'b1;
      else
         rx_level_q <= rx_level_d;
   end

   // pulse seen in the current bit, held until count eight
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         bit_zero_q <= 1'b0;
      else
         bit_zero_q <= bit_zero_d;
   end

   // transmit pin; resets high as a bypassed uart line idles
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_txd_pin <= 1'b1;
      else
         o_txd_pin <= txd_pin_d;
   end

   // uart receive level
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_uart_rxd <= 1'b1;
      else
         o_uart_rxd <= uart_rxd_d;
   end

   // baud tick for the uart, one clock behind the internal tick
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_baud_tick <= 1'b0;
      else
         o_baud_tick <= tick;
   end

   // busy from the next state so tx is blocked from the edge onward
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_rx_busy <= 1'b0;
      else
         o_rx_busy <= rx_busy_d;
   end
endmodule : infrared_pulse_endec

// [ir_endec_checker.sv]
// port assertions for the infrared pulse encoder/decoder
`timescale 1ns/100ps
module ir_endec_checker
(
   input wire logic       i_ref_clk,
   input wire logic       i_sys_rst,
   input wire logic       i_infrared_codec_enable,
   input wire logic [7:0] i_divisor_high,
   input wire logic [7:0] i_divisor_low,
   input wire logic       i_uart_txd,
   input wire logic       i_rxd_pin,
   input wire logic       o_txd_pin,
   input wire logic       o_uart_rxd,
   input wire logic       o_baud_tick,
   input wire logic       o_rx_busy
);
   logic [3:0] hi_cnt_q;
   logic [4:0] rx_cnt_q;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   // ticks under a led pulse and since the decoder woke; rx count saturates
   always_ff @(posedge i_ref_clk)
   begin
      hi_cnt_q <= (i_sys_rst || !o_txd_pin || !i_infrared_codec_enable) ? 4'h0
                  : hi_cnt_q + 4'(o_baud_tick);
      rx_cnt_q <= (i_sys_rst || !o_rx_busy) ? 5'h00
                  : rx_cnt_q + 5'(o_baud_tick && rx_cnt_q != 5'h1F);
   end
   property p_tick_one;
      o_baud_tick && {i_divisor_high, i_divisor_low} > 16'h0001 |=> !o_baud_tick;
   endproperty
   a_tick_one: assert property (p_tick_one) else $error("baud tick too wide");
   property p_tx_bypass;
      !i_infrared_codec_enable && !$past(i_infrared_codec_enable)
         |-> o_txd_pin == $past(i_uart_txd);
   endproperty
   a_tx_bypass: assert property (p_tx_bypass) else $error("tx bypass wrong");
   property p_pulse_len;
      $fell(o_txd_pin) && $past(i_infrared_codec_enable, 3) |-> hi_cnt_q == 4'h3;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("led pulse not three ticks");
   property p_half_duplex;
      i_infrared_codec_enable && o_rx_busy && $past(o_rx_busy) |-> !$rose(o_txd_pin);
   endproperty
   a_half_duplex: assert property (p_half_duplex) else $error("pulse sent while receiving");
   property p_rx_lag;
      $fell(o_uart_rxd) && i_infrared_codec_enable && rx_cnt_q < 5'h0C
         |-> rx_cnt_q inside {[5'h08:5'h09]};
   endproperty
   a_rx_lag: assert property (p_rx_lag) else $error("rx level not eight ticks late");
   property p_idle_high;
      (i_infrared_codec_enable && !o_rx_busy) [*2] |-> o_uart_rxd;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle rx level low");
   property p_rx_bypass;
      (!i_infrared_codec_enable && $stable(i_rxd_pin)) [*4] |-> o_uart_rxd == i_rxd_pin;
   endproperty
   a_rx_bypass: assert property (p_rx_bypass) else $error("rx bypass wrong");
   property p_wake;
      i_infrared_codec_enable && $fell(i_rxd_pin) |-> ##[1:4] o_rx_busy;
   endproperty
   a_wake: assert property (p_wake) else $error("edge did not start decoder");
endmodule : ir_endec_checker
bind infrared_pulse_endec ir_endec_checker chk (.*);

// [ir_endec_pkg.sv]
// constants for the infrared pulse encoder/decoder
package ir_endec_pkg;
   localparam int unsigned TICKS_PER_BIT  = 16;   // baud ticks per bit
   localparam logic [3:0]  TX_PULSE_START = 4'h7; // first high tick
   localparam logic [3:0]  TX_PULSE_END   = 4'hA; // first low tick after pulse
   localparam logic [3:0]  RX_UPDATE_CNT  = 4'h8; // rx level update point
   localparam logic [3:0]  RX_WIN_OPEN    = 4'hC; // window opens
   localparam logic [3:0]  CNT_LAST       = 4'hF;
   localparam logic [15:0] DIVISOR_RESET  = 16'hFFFF;
   localparam logic [15:0] DIVISOR_ONE    = 16'h0001;
   typedef enum logic [1:0]
   {
      RX_IDLE   = 2'b00,
      RX_FIRST  = 2'b01,
      RX_WINDOW = 2'b11
   } rx_state_e;
endpackage : ir_endec_pkg

// [ir_xcvr_model.sv]
// infrared transceiver stand-in: sends pulse frames, counts led pulses
`timescale 1ns/100ps
module ir_xcvr_model
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_tick,
   input  wire logic       i_led,
   input  wire logic       i_go,
   input  wire logic [7:0] i_data,
   output logic            o_pulse = 1'b0,
   output logic            o_strobe = 1'b0,
   output int              o_rises = 0
);
   logic [9:0] frame_q;
   logic       led_q = 1'b0;
   int         n_q   = 0;
   int         tck_q = 0;
   // sender idles low (no light); strobe marks each bit start
   always @(posedge i_ref_clk)
   begin
      led_q    <= i_led;
      o_rises  <= o_rises + int'(i_led && !led_q);
      o_strobe <= i_tick && n_q != 0 && tck_q == 0;
      if (i_go)
      begin
         frame_q <= {1'b1, i_data, 1'b0};
         n_q     <= 11;
         tck_q   <= 0;
      end
      else if (i_tick && n_q != 0)
      begin
         o_pulse <= tck_q < 3 && !frame_q[0];
         tck_q   <= (tck_q + 1) % 16;
         if (tck_q == 15)
         begin
            frame_q <= {1'b1, frame_q[9:1]};
            n_q     <= n_q - 1;
         end
      end
   end
endmodule : ir_xcvr_model

// [testbench.sv]
// self-checking bench for the infrared pulse encoder/decoder
`timescale 1ns/100ps
module testbench;
   import ir_endec_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       en  = 1'b0;
   logic       txd = 1'b1;
   logic       go  = 1'b0;
   logic [7:0] dat = 8'h00;
   logic       pulse, strobe, txp, rxd, tick, busy;
   int         rises;
   int         n_fail = 0;
   int         tests_run = 0;
   // 40 MHz clock
   initial forever #12.5 clk = ~clk;
   infrared_pulse_endec dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_infrared_codec_enable(en),
      .i_divisor_high(8'h00), .i_divisor_low(8'h04), .i_uart_txd(txd), .i_rxd_pin(pulse),
      .o_txd_pin(txp), .o_uart_rxd(rxd), .o_baud_tick(tick), .o_rx_busy(busy));
   ir_xcvr_model xcvr (.i_ref_clk(clk), .i_tick(tick), .i_led(txp), .i_go(go), .i_data(dat),
      .o_pulse(pulse), .o_strobe(strobe), .o_rises(rises));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // waits settled after each of n baud ticks
   task automatic ticks(input int n);
      repeat (n) do step(1); while (tick !== 1'b1);
   endtask : ticks
   task automatic t_bypass();
      int c;
      txd = 1'b0;
      step(2);
      check("bypass tx low", txp, 0);
      txd = 1'b1;
      step(2);
      check("bypass tx high", txp, 1);
      ticks(1);
      c = 0;
      do begin step(1); c++; end while (tick !== 1'b1);
      check("tick period", c, 4);
      $display("test bypass done");
   endtask : t_bypass
   // 64 ticks span exactly four frames whatever the frame phase
   task automatic t_tx();
      int r0;
      en = 1'b1;
      ticks(32);
      r0 = rises;
      ticks(64);
      check("pulses for ones", rises - r0, 0);
      txd = 1'b0;
      ticks(16);
      r0 = rises;
      ticks(64);
      check("pulses for zeros", rises - r0, 4);
      txd = 1'b1;
      ticks(32);
      $display("test tx done");
   endtask : t_tx
   // each bit read at the next bit start, after the eight tick lag;
   // with tx_zero the uart sends zeros that half duplex keeps off the led
   task automatic t_rx(input logic [7:0] d, input logic tx_zero);
      logic [9:0] got;
      int         r0;
      dat = d;
      txd = ~tx_zero;
      go = 1'b1;
      step(1);
      go = 1'b0;
      r0 = rises;
      for (int k = 0; k < 11; k++)
      begin
         do step(1); while (strobe !== 1'b1);
         if (k > 0) got[k-1] = rxd;
         if (k == 1) r0 = rises;
         if (tx_zero && k > 0 && k < 10) check("busy in frame", busy, 1);
         if (tx_zero && k == 9) check("led pulses while receiving", rises - r0, 0);
      end
      txd = 1'b1;
      check("rx frame", got, {1'b1, d, 1'b0});
      check("busy after frame", busy, 0);
      check("rx idle level", rxd, 1);
      $display("test rx done");
   endtask : t_rx
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      step(12);
      rst = 1'b0;
      t_bypass();
      t_tx();
      t_rx(8'hA5, 1'b0);
      t_rx(8'h00, 1'b1);
      complete_run();
   end
   // runs need about 54 us
   initial
   begin
      #500000;
      n_fail++;
      complete_run();
   end
endmodule : testbench
